// ===== logic/smac_top.v
// Switch memory access command decoder: data, address and command
// registers reach the upstream tristate field and the control memory,
// and the stored fields steer the PCM and downstream line outputs.
// Assumes all inputs synchronous to clk (20 MHz reference clock).
// Memories have no reset of their own: a sweep after reset clears
// codes and tristate bits, with busy held high until it ends.
`timescale 1ns/1ps
`include "smac_defines.vh"

module smac_top #(
  parameter TS_DEPTH = 128,
  parameter CM_DEPTH = 256,
  parameter ALL_TS_CYC = `SMAC_ALL_TS_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Upstream PCM transmit slot
  input wire [6:0] pcm_slot,
  input wire [2:0] pcm_bit_pos,
  input wire pcm_bit,
  output reg pcm_txd,
  output reg pcm_txd_oe_n,
  output reg tristate_control_line_n,
  // Downstream line interface slot
  input wire [7:0] line_slot,
  input wire [2:0] line_bit_pos,
  input wire line_bit,
  output reg line_out,
  output reg line_oe_n,
  // Status
  output reg memory_access_busy_flag
);

  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_ALL = 2'd2;
  localparam ST_INIT = 2'd3;

  localparam OP_NONE = 3'd0;
  localparam OP_TS_WR = 3'd1;
  localparam OP_TS_RD = 3'd2;
  localparam OP_CMD_WR = 3'd3;
  localparam OP_CMD_RD = 3'd4;
  localparam OP_CODE_WR = 3'd5;
  localparam OP_CODE_RD = 3'd6;

  localparam [10:0] SINGLE_CNT = `SMAC_SINGLE_CYC;
  localparam [10:0] ALL_CNT = ALL_TS_CYC;

  //////////////////////////////////////////////////////////////////////
  // Storage

  reg [3:0] ts_mem [0:TS_DEPTH-1];
  reg [7:0] cm_data [0:CM_DEPTH-1];
  reg [3:0] cm_code [0:CM_DEPTH-1];

  reg [7:0] memory_access_data;
  reg [7:0] memory_access_address;
  reg [7:0] memory_access_command;
  reg output_style_bit;
  reg [1:0] subchannel_select_register;

  reg [1:0] state;
  reg [2:0] op;
  reg [10:0] cnt;
  reg [7:0] sweep;

  wire cmd_wr = reg_wr && (reg_addr == `SMAC_OFS_CMD);
  wire [6:0] ts_idx = memory_access_address[6:0];
  wire [7:0] cm_idx = memory_access_address;
  wire last = (cnt == 11'd1);

  //////////////////////////////////////////////////////////////////////
  // Command decode

  reg [2:0] next_op;

  // Operation picked from the written command byte
  always @* begin
    next_op = OP_NONE;
    case (reg_wdata)
      `SMAC_CMD_TS_WR: next_op = OP_TS_WR;
      `SMAC_CMD_TS_RD: next_op = OP_TS_RD;
      `SMAC_CMD_CMD_WR: next_op = OP_CMD_WR;
      `SMAC_CMD_CMD_RD: next_op = OP_CMD_RD;
      default: begin
        if (reg_wdata[6:4] == `SMAC_MOC_CODE_HI) begin
          if (reg_wdata[`SMAC_CMD_RD_BIT])
            next_op = OP_CODE_RD;
          else
            next_op = OP_CODE_WR;
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Sequencer and busy flag

  always @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_INIT;
      op <= OP_NONE;
      cnt <= 11'd0;
      sweep <= 8'h00;
      memory_access_busy_flag <= 1'b1;
    end else begin
      case (state)
        ST_INIT: begin
          // Clear codes and tristate bits after reset
          sweep <= sweep + 8'h01;
          if (sweep == 8'hFF) begin
            state <= ST_IDLE;
            memory_access_busy_flag <= 1'b0;
          end
        end
        ST_IDLE: begin
          if (cmd_wr) begin
            // all slots run the long count
            if (reg_wdata == `SMAC_CMD_TS_ALL) begin
              state <= ST_ALL;
              cnt <= ALL_CNT;
              sweep <= 8'h00;
              memory_access_busy_flag <= 1'b1;
            end else if (next_op != OP_NONE) begin
              state <= ST_WAIT;
              op <= next_op;
              cnt <= SINGLE_CNT;
              memory_access_busy_flag <= 1'b1;
            end
          end
        end
        ST_WAIT: begin
          cnt <= cnt - 11'd1;
          if (last) begin
            state <= ST_IDLE;
            op <= OP_NONE;
            memory_access_busy_flag <= 1'b0;
          end
        end
        ST_ALL: begin
          cnt <= cnt - 11'd1;
          if (sweep != 8'hFF)
            sweep <= sweep + 8'h01;
          if (last) begin
            state <= ST_IDLE;
            memory_access_busy_flag <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
          memory_access_busy_flag <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Tristate field writes

  always @(posedge clk) begin
    if (state == ST_WAIT && last && op == OP_TS_WR)
      ts_mem[ts_idx] <= memory_access_data[3:0];
    else if (state == ST_ALL && sweep < TS_DEPTH)
      ts_mem[sweep[6:0]] <= memory_access_data[3:0];
    else if (state == ST_INIT && sweep < TS_DEPTH)
      ts_mem[sweep[6:0]] <= 4'h0;
  end

  //////////////////////////////////////////////////////////////////////
  // Control memory writes

  always @(posedge clk) begin
    // data stored raw, meaning per code
    if (state == ST_WAIT && last && (op == OP_CMD_WR || op == OP_CODE_WR))
      cm_data[cm_idx] <= memory_access_data;
  end

  always @(posedge clk) begin
    if (state == ST_WAIT && last && op == OP_CODE_WR)
      cm_code[cm_idx] <= memory_access_command[3:0];
    else if (state == ST_INIT)
      cm_code[sweep] <= `SMAC_CODE_UNASSIGNED;
  end

  //////////////////////////////////////////////////////////////////////
  // Software registers

  // Address register; it is used at completion, so software leaves
  // it alone while busy is high
  always @(posedge clk) begin
    if (!rst_n)
      memory_access_address <= `SMAC_RST_BYTE;
    else if (reg_wr && reg_addr == `SMAC_OFS_ADDR)
      memory_access_address <= reg_wdata;
  end

  // Command register; writes while busy are refused so that a running
  // code write keeps its code bits
  always @(posedge clk) begin
    if (!rst_n)
      memory_access_command <= `SMAC_RST_BYTE;
    else if (cmd_wr && !memory_access_busy_flag)
      memory_access_command <= reg_wdata;
  end

  // Output style bit of the mode register
  always @(posedge clk) begin
    if (!rst_n)
      output_style_bit <= 1'b0;
    else if (reg_wr && reg_addr == `SMAC_OFS_MODE)
      output_style_bit <= reg_wdata[`SMAC_MODE_STYLE_BIT];
  end

  // Subslot select for the downstream subchannels
  always @(posedge clk) begin
    if (!rst_n)
      subchannel_select_register <= `SMAC_RST_SUBSEL;
    else if (reg_wr && reg_addr == `SMAC_OFS_SUBSEL)
      subchannel_select_register <= reg_wdata[1:0];
  end

  // Data register; a read result beats a software write in the same
  // cycle, so software must wait for busy low before writing it
  always @(posedge clk) begin
    if (!rst_n)
      memory_access_data <= `SMAC_RST_BYTE;
    else if (state == ST_WAIT && last && op == OP_TS_RD)
      memory_access_data <= {4'h0, ts_mem[ts_idx]};
    else if (state == ST_WAIT && last && op == OP_CMD_RD)
      memory_access_data <= cm_data[cm_idx];
    else if (state == ST_WAIT && last && op == OP_CODE_RD)
      memory_access_data <= {4'h0, cm_code[cm_idx]};
    else if (reg_wr && reg_addr == `SMAC_OFS_DATA)
      memory_access_data <= reg_wdata;
  end

  //////////////////////////////////////////////////////////////////////
  // Read port: data stand in the cycle after the strobe only

  reg [7:0] next_rdata;

  // Register select; unmapped offsets read zero
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `SMAC_OFS_DATA: next_rdata = memory_access_data;
      `SMAC_OFS_ADDR: next_rdata = memory_access_address;
      `SMAC_OFS_CMD: next_rdata = memory_access_command;
      `SMAC_OFS_STATUS: next_rdata = {7'h00, memory_access_busy_flag};
      `SMAC_OFS_MODE: next_rdata = {7'h00, output_style_bit};
      `SMAC_OFS_SUBSEL: next_rdata = {6'h00, subchannel_select_register};
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data register, back to zero after one cycle
  always @(posedge clk) begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 8'h00;
  end

  //////////////////////////////////////////////////////////////////////
  // Upstream PCM drivers

  // bit pair picks its enable bit
  wire [3:0] pcm_ts = ts_mem[pcm_slot];
  wire pcm_en = pcm_ts[pcm_bit_pos[2:1]];

  always @(posedge clk) begin
    if (!rst_n) begin
      pcm_txd <= 1'b0;
      pcm_txd_oe_n <= 1'b1;
      tristate_control_line_n <= 1'b1;
    end else begin
      pcm_txd <= pcm_en ? pcm_bit : 1'b0;
      pcm_txd_oe_n <= ~pcm_en;
      tristate_control_line_n <= ~pcm_en;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Downstream line drivers

  wire [3:0] line_code = cm_code[line_slot];
  reg line_act;
  reg next_line_out;
  reg next_line_oe_n;

  // Slot activity from its code and the subslot select
  always @* begin
    line_act = 1'b1;
    case (line_code)
      `SMAC_CODE_UNASSIGNED: line_act = 1'b0;
      `SMAC_CODE_SW8: line_act = 1'b1;
      `SMAC_CODE_SW4_LO,
      `SMAC_CODE_SW4_HI: line_act = (line_bit_pos[2] == subchannel_select_register[1]);
      default: begin
        if (line_code > `SMAC_CODE_SW4_HI && line_code <= `SMAC_CODE_SW2_LAST)
          line_act = (line_bit_pos[2:1] == subchannel_select_register);
        else
          line_act = 1'b1;
      end
    endcase
  end

  // Driver style of the downstream pin
  always @* begin
    next_line_out = 1'b0;
    next_line_oe_n = 1'b1;
    if (output_style_bit) begin
      next_line_oe_n = ~(line_act && !line_bit);
    end else begin
      next_line_out = line_act & line_bit;
      next_line_oe_n = ~line_act;
    end
  end

  // Pin registers, quiet during reset
  always @(posedge clk) begin
    if (!rst_n) begin
      line_out <= 1'b0;
      line_oe_n <= 1'b1;
    end else begin
      line_out <= next_line_out;
      line_oe_n <= next_line_oe_n;
    end
  end

endmodule

// ===== shared/smac_defines.vh
// Constants of the switch memory access command decoder.
// Included by logic/smac_top.v; holds definitions only.
//
// Functional notes
// - Each tristate bit enables one 2-bit pair
// - Upper data bits ignored on tristate writes
// - Command 60h writes one slot tristate field
// - Command E0h reads one slot tristate field
// - Command 68h writes every tristate field
// - Tristate accesses force the upstream bit
// - Busy flag high until read data ready
// - Data field meaning follows slot code
// - Code 111X writes data and code fields
// - Code 1001 touches data field only
// - 48h writes, C8h reads control data field
// - 111X read returns 4-bit code low bits
// - Switching codes select transferred bit groups
// - Codes 1000,1010,1011 preprocessed; 1001 processor
// - Code 0000 keeps downstream output inactive
// - Subchannels drive only in selected subslot
// - Style bit picks tristate or open drain
// - Driven PCM subslot pulls control line low
// - All-slot tristate write busy 1035 cycles
// - Single access completes in 9.5 cycles; the code holds busy for 10
`ifndef SMAC_DEFINES_VH
`define SMAC_DEFINES_VH

// Register offsets on the plain port
`define SMAC_OFS_DATA 3'h0
`define SMAC_OFS_ADDR 3'h1
`define SMAC_OFS_CMD 3'h2
`define SMAC_OFS_STATUS 3'h3
`define SMAC_OFS_MODE 3'h4
`define SMAC_OFS_SUBSEL 3'h5

// Field positions
`define SMAC_CMD_RD_BIT 7
`define SMAC_STAT_BUSY_BIT 0
`define SMAC_MODE_STYLE_BIT 0

// Reset values
`define SMAC_RST_BYTE 8'h00
`define SMAC_RST_SUBSEL 2'h0

// Command bytes
`define SMAC_CMD_TS_WR 8'h60
`define SMAC_CMD_TS_RD 8'hE0
`define SMAC_CMD_TS_ALL 8'h68
`define SMAC_CMD_CMD_WR 8'h48
`define SMAC_CMD_CMD_RD 8'hC8
`define SMAC_MOC_CODE_HI 3'h7

// Control memory codes
`define SMAC_CODE_UNASSIGNED 4'h0
`define SMAC_CODE_SW8 4'h1
`define SMAC_CODE_SW4_LO 4'h2
`define SMAC_CODE_SW4_HI 4'h3
`define SMAC_CODE_SW2_LAST 4'h7

// Timing: single access in half reference cycles, rounded up to cycles
`define SMAC_SINGLE_HALF_CYC 19
`define SMAC_SINGLE_CYC ((`SMAC_SINGLE_HALF_CYC + 1) / 2)
`define SMAC_ALL_TS_CYC 1035

`endif

// ===== sim/smac_assertions.sv
// Port checker of the memory access decoder.
// Bound to smac_top; sees only its ports.
`timescale 1ns/1ps
module smac_assertions #(parameter ALL_TS_CYC = 1035) (
  // Clock, reset and register writes
  input wire clk,
  input wire rst_n,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  // Line data bits, outputs and status
  input wire pcm_bit,
  input wire pcm_txd,
  input wire pcm_txd_oe_n,
  input wire tristate_control_line_n,
  input wire line_bit,
  input wire line_out,
  input wire line_oe_n,
  input wire memory_access_busy_flag
);
  wire busy = memory_access_busy_flag;
  wire cmd = reg_wr && reg_addr == 3'h2 && !busy;
  wire known = reg_wdata == 8'h60 || reg_wdata == 8'hE0 || reg_wdata == 8'h68 || reg_wdata == 8'h48
    || reg_wdata == 8'hC8 || reg_wdata[7:4] == 4'h7 || reg_wdata[7:4] == 4'hF;
  reg od;
  reg all;
  reg [11:0] cnt;
  // Style bit, last command kind and busy length
  always @(posedge clk) begin
    if (!rst_n) begin
      od <= 1'b0;
      all <= 1'b0;
      cnt <= 12'h000;
    end else begin
      if (reg_wr && reg_addr == 3'h4) od <= reg_wdata[0];
      if (cmd && known) all <= reg_wdata == 8'h68;
      cnt <= busy ? cnt + 12'h001 : 12'h000;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_start; cmd && known |=> busy; endproperty
  a_start: assert property (p_start) else $error("busy did not rise");
  property p_unknown; cmd && !known |=> !busy; endproperty
  a_unknown: assert property (p_unknown) else $error("unknown command started");
  property p_single; cmd && known && reg_wdata != 8'h68 |=> busy [*8] ##1 busy [*2] ##1 !busy; endproperty
  a_single: assert property (p_single) else $error("single access length");
  property p_all; $fell(busy) && all |-> cnt == ALL_TS_CYC; endproperty
  a_all: assert property (p_all) else $error("fill access length");
  property p_pcm_on; !pcm_txd_oe_n |-> !tristate_control_line_n && pcm_txd == $past(pcm_bit); endproperty
  a_pcm_on: assert property (p_pcm_on) else $error("driven subslot wrong");
  property p_pcm_off; pcm_txd_oe_n |-> tristate_control_line_n && !pcm_txd; endproperty
  a_pcm_off: assert property (p_pcm_off) else $error("floating subslot wrong");
  property p_line_on; !line_oe_n |-> line_out == $past(line_bit); endproperty
  a_line_on: assert property (p_line_on) else $error("line data wrong");
  property p_line_od; od && $past(od) && $past(line_bit) |-> line_oe_n; endproperty
  a_line_od: assert property (p_line_od) else $error("open drain drove one");
  c_all: cover property (cmd && reg_wdata == 8'h68);
  c_od: cover property (od && !line_oe_n);
  c_pcm: cover property (!pcm_txd_oe_n);
endmodule
bind smac_top smac_assertions #(.ALL_TS_CYC(ALL_TS_CYC)) smac_assertions_i (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .pcm_bit(pcm_bit), .pcm_txd(pcm_txd),
  .pcm_txd_oe_n(pcm_txd_oe_n), .tristate_control_line_n(tristate_control_line_n), .line_bit(line_bit),
  .line_out(line_out), .line_oe_n(line_oe_n), .memory_access_busy_flag(memory_access_busy_flag));

// ===== sim/smac_frame_gen.sv
// Frame timing model: walks every slot and bit position.
// Assumes the decoder's clock and reset.
`timescale 1ns/1ps
module smac_frame_gen (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Slot positions and data bits
  output wire [6:0] pcm_slot,
  output wire [2:0] pcm_bit_pos,
  output wire pcm_bit,
  output wire [7:0] line_slot,
  output wire [2:0] line_bit_pos,
  output wire line_bit
);
  reg [10:0] cnt;
  // Free counter, one step per clock
  always @(posedge clk) begin
    cnt <= rst_n ? cnt + 11'h001 : 11'h000;
  end
  assign pcm_slot = cnt[6:0];
  assign pcm_bit_pos = cnt[9:7];
  assign pcm_bit = cnt[0] ^ cnt[4] ^ cnt[9];
  assign line_slot = cnt[7:0];
  assign line_bit_pos = cnt[10:8];
  assign line_bit = cnt[1] ^ cnt[6] ^ cnt[10];
endmodule

// ===== sim/switch_memory_access_commands_tb.sv
// Self-checking bench of the memory access decoder.
// Assumes smac_top, smac_frame_gen and the bound checker.
`timescale 1ns/1ps
module switch_memory_access_commands_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [2:0] reg_addr = 3'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  wire [7:0] reg_rdata;
  wire [6:0] pcm_slot;
  wire [2:0] pcm_bit_pos;
  wire [7:0] line_slot;
  wire [2:0] line_bit_pos;
  wire pcm_bit, pcm_txd, pcm_txd_oe_n, tsc_n, line_bit, line_out, line_oe_n, busy;
  reg [3:0] ts [0:127];
  reg [3:0] code [0:255];
  reg [7:0] cmem [0:255];
  reg cm_ok [0:255];
  reg [6:0] p_ps;
  reg [2:0] p_pp, p_lp;
  reg [7:0] p_ls, a, d, r;
  reg p_pb, p_lb, e, mode;
  reg [1:0] sub;
  reg [31:0] lfsr;
  integer err_count, compares, q, i, n;
  always #25 clk = ~clk;
  smac_top #(.ALL_TS_CYC(200)) smac_top_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pcm_slot(pcm_slot),
    .pcm_bit_pos(pcm_bit_pos), .pcm_bit(pcm_bit), .pcm_txd(pcm_txd), .pcm_txd_oe_n(pcm_txd_oe_n),
    .tristate_control_line_n(tsc_n), .line_slot(line_slot), .line_bit_pos(line_bit_pos),
    .line_bit(line_bit), .line_out(line_out), .line_oe_n(line_oe_n), .memory_access_busy_flag(busy));
  smac_frame_gen smac_frame_gen_i (.clk(clk), .rst_n(rst_n), .pcm_slot(pcm_slot), .pcm_bit_pos(pcm_bit_pos),
    .pcm_bit(pcm_bit), .line_slot(line_slot), .line_bit_pos(line_bit_pos), .line_bit(line_bit));
  ////////////////////////////////////////////////////////////
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Line slot activity from code and subslot select
  function act(input [3:0] cd, input [2:0] pos, input [1:0] s);
    if (cd == 4'h0) act = 1'b0;
    else if (cd[3:1] == 3'h1) act = pos[2] == s[1];
    else if (cd[3:2] == 2'h1) act = pos[2:1] == s;
    else act = 1'b1;
  endfunction
  task chk(input [63:0] nm, input [7:0] ex, input [7:0] g);
    begin
      compares = compares + 1;
      if (g !== ex) begin
        err_count = err_count + 1;
        $display("wrong value %0s expected %h seen %h", nm, ex, g);
      end
    end
  endtask
  task end_sim;
    begin
      if (err_count == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task wr(input [2:0] ad, input [7:0] v);
    begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [2:0] ad, output [7:0] v);
    begin
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
    end
  endtask
  task wait_idle;
    begin
      n = 0;
      r = 8'h01;
      while (r[0] !== 1'b0) begin
        rd(3'h3, r);
        n = n + 1;
        if (n > 400) begin
          err_count = err_count + 1;
          end_sim;
        end
      end
    end
  endtask
  task cmdw(input [7:0] c);
    begin
      wr(3'h0, d);
      wr(3'h1, a);
      wr(3'h2, c);
      wait_idle;
    end
  endtask
  ////////////////////////////////////////////////////////////
  // Compare both output paths with the stored fields
  always @(posedge clk) begin
    if (!rst_n || busy !== 1'b0 || reg_wr === 1'b1) q = 0;
    else if (q < 4) q = q + 1;
    else begin
      e = ts[p_ps][p_pp[2:1]];
      chk("pcm_oe", {7'h00, !e}, {7'h00, pcm_txd_oe_n});
      chk("tsc", {7'h00, !e}, {7'h00, tsc_n});
      if (e) chk("pcm_d", {7'h00, p_pb}, {7'h00, pcm_txd});
      e = act(code[p_ls], p_lp, sub);
      chk("line_oe", {7'h00, !(e && !(mode && p_lb))}, {7'h00, line_oe_n});
      chk("line_d", {7'h00, e && !mode && p_lb}, {7'h00, line_out});
    end
    p_ps = pcm_slot;
    p_pp = pcm_bit_pos;
    p_pb = pcm_bit;
    p_ls = line_slot;
    p_lp = line_bit_pos;
    p_lb = line_bit;
  end
  initial begin
    err_count = 0;
    compares = 0;
    q = 0;
    mode = 1'b0;
    sub = 2'h0;
    lfsr = 32'h0000AF7A;
    for (i = 0; i < 256; i = i + 1) begin
      code[i] = 4'h0;
      cm_ok[i] = 1'b0;
      if (i < 128) ts[i] = 4'h0;
    end
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wait_idle;
    chk("status", 8'h00, r);
    rd(3'h7, r);
    chk("unmapped", 8'h00, r);
    for (i = 0; i < 80; i = i + 1) begin
      lfsr = nxt(lfsr);
      a = lfsr[7:0] & 8'h8F;
      d = i == 0 ? 8'hFF : lfsr[15:8];
      case (i == 0 ? 4'h3 : lfsr[19:16])
        4'h0, 4'h1: begin
          cmdw(8'h60);
          ts[a[6:0]] = d[3:0];
        end
        4'h2: begin
          cmdw(8'hE0);
          rd(3'h0, r);
          chk("ts_rd", {4'h0, ts[a[6:0]]}, r);
        end
        4'h3: begin
          cmdw(8'h68);
          for (n = 0; n < 128; n = n + 1) ts[n] = d[3:0];
        end
        4'h4: begin
          cmem[a] = d;
          cm_ok[a] = 1'b1;
          cmdw(8'h48);
        end
        4'h5: begin
          cmdw(8'hC8);
          rd(3'h0, r);
          if (cm_ok[a]) chk("cm_rd", cmem[a], r);
        end
        4'h6, 4'h7, 4'h8: begin
          cmdw({4'h7, lfsr[23:20]});
          code[a] = lfsr[23:20];
          cmem[a] = d;
          cm_ok[a] = 1'b1;
        end
        4'h9, 4'hA: begin
          cmdw({4'hF, lfsr[23:20]});
          rd(3'h0, r);
          chk("code_rd", {4'h0, code[a]}, {4'h0, r[3:0]});
        end
        4'hD: begin
          wr(3'h4, d);
          mode = d[0];
        end
        4'hE: begin
          wr(3'h5, d);
          sub = d[1:0];
        end
        default: begin
          wr(3'h2, {lfsr[22], 3'h0, lfsr[23], 3'h0});
          rd(3'h3, r);
          chk("busy", 8'h00, r);
        end
      endcase
      repeat (60) @(posedge clk);
    end
    end_sim;
  end
endmodule
